// File: dv/tb_top.sv
// Self-checking testbench for the upper timer stage control
`timescale 1ns/10ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] a = 4'h0;
  logic [7:0] d = 8'h00;
  logic w = 1'b0;
  logic r = 1'b0;
  logic fc = 1'b0;
  logic fs = 1'b0;
  logic pin = 1'b0;
  logic cas = 1'b0;
  logic en = 1'b1;
  logic [7:0] q;
  logic [7:0] v;
  logic ff;
  logic tk;
  logic mi;
  logic irq;
  int num_errors = 0;
  int n_checks = 0;
  utsc_top i_utsc_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(en),
    .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(w), .reg_rd_i(r), .reg_rdata_o(q),
    .fc_tick_i(fc), .fs_tick_i(fs), .count_pin_i(pin), .cascade_overflow_i(cas),
    .timer_ff_o(ff), .count_tick_o(tk), .stage_match_interrupt_o(mi), .irq_o(irq));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clock_i);
    a <= ad;
    d <= dt;
    w <= 1'b1;
    @(posedge clock_i);
    w <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clock_i);
    a <= ad;
    r <= 1'b1;
    @(posedge clock_i);
    r <= 1'b0;
    #1 v = q;
  endtask
  // One cycle of source pulses; tick checked when k is set
  task automatic pl(input logic f, input logic s, input logic c, input logic k, input logic e);
    @(posedge clock_i);
    fc <= f;
    fs <= s;
    cas <= c;
    #1;
    if (k) chk({7'h00, tk}, {7'h00, e});
    @(posedge clock_i);
    fc <= 1'b0;
    fs <= 1'b0;
    cas <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(4'h0);
    chk(v, 8'h00);
    rd(4'h1);
    chk(v, 8'hFF);
    rd(4'h2);
    chk(v, 8'h00);
    wr(4'h9, 8'h5A);
    rd(4'h9);
    chk(v, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(4'h0, {m[2:0], 5'h0C});
      rd(4'h0);
      chk(v, {m[2:0], 5'h0C});
    end
    $display("t_modes done");
  endtask
  task automatic t_timer;
    wr(4'h1, 8'h03);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h1C);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(4'h6);
    chk(v, 8'h02);
    wr(4'h0, 8'h1C);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(4'h6);
    chk(v, 8'h00);
    chk({7'h00, mi}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(4'h4, 8'h00);
    rd(4'h3);
    chk({7'h00, v[0]}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(4'h3, 8'h01);
    rd(4'h3);
    chk({7'h00, v[0] | mi}, 8'h00);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(4'h0, 8'h0C);
    rd(4'h6);
    chk(v, 8'h00);
    $display("t_timer done");
  endtask
  task automatic t_ff;
    wr(4'h0, 8'h11);
    chk({7'h00, ff}, 8'h01);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h10);
    chk({7'h00, ff}, 8'h00);
    wr(4'h0, 8'h00);
    $display("t_ff done");
  endtask
  task automatic t_src;
    logic [2:0] wm;
    for (int s = 0; s < 2; s++) begin
      wr(4'h7, {6'h00, s[0], 1'b0});
      for (int c = 1; c < 7; c++) begin
        wm = (s == 1 && c == 6) ? 3'h5 : 3'h0;
        wr(4'h0, {wm, 1'b1, c[2:0], 1'b0});
        pl(1'b1, 1'b0, 1'b0, s[0] || c == 6, c == 6 && s == 0);
        pl(1'b0, 1'b1, 1'b0, c == 4 || c == 6, c == 4);
        wr(4'h0, {wm, 1'b0, c[2:0], 1'b0});
      end
    end
    wr(4'h7, 8'h00);
    $display("t_src done");
  endtask
  task automatic t_pin;
    int n;
    n = 0;
    wr(4'h0, 8'h1E);
    @(posedge clock_i);
    pin <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      #1;
      if (tk === 1'b1) n++;
    end
    chk(n[7:0], 8'h01);
    pin <= 1'b0;
    rd(4'h6);
    chk(v, 8'h01);
    wr(4'h0, 8'h0E);
    $display("t_pin done");
  endtask
  task automatic t_casc;
    wr(4'h5, 8'h6C);
    wr(4'h0, 8'h9C);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    pl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    rd(4'h6);
    chk(v, 8'h01);
    wr(4'h0, 8'h8C);
    $display("t_casc done");
  endtask
  task automatic t_pwm;
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h3C);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({7'h00, ff}, 8'h00);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({7'h00, ff}, 8'h01);
    wr(4'h0, 8'h2C);
    wr(4'h1, 8'hFF);
    wr(4'h2, 8'h02);
    wr(4'h0, 8'h5C);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({7'h00, ff}, 8'h00);
    pl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({7'h00, ff}, 8'h01);
    wr(4'h0, 8'h4C);
    $display("t_pwm done");
  endtask
  task automatic t_freeze;
    wr(4'h0, 8'h1C);
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    @(posedge clock_i);
    en <= 1'b0;
    pl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clock_i);
    en <= 1'b1;
    rd(4'h6);
    chk(v, 8'h01);
    wr(4'h0, 8'h0C);
    $display("t_freeze done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    $display("unexpected at %0t got %h exp %h", $time, 8'h00, 8'h01);
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_modes();
    t_timer();
    t_pwm();
    t_ff();
    t_src();
    t_pin();
    t_casc();
    t_freeze();
    wrap_up();
  end
endmodule

// File: dv/utsc_monitor.sv
// Port assertions for the upper timer stage control
`timescale 1ns/10ps
module utsc_monitor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Sources and outputs
  input wire logic fc_tick_i,
  input wire logic fs_tick_i,
  input wire logic cascade_overflow_i,
  input wire logic timer_ff_o,
  input wire logic count_tick_o,
  input wire logic stage_match_interrupt_o,
  input wire logic irq_o
);
  logic run;
  logic slow;
  logic msk;
  logic [2:0] ck;
  logic [2:0] md;
  logic cw;
  logic sw;
  logic clr;
  logic en;
  assign en = clk_en_i && run;
  assign cw = reg_wr_i && clk_en_i && reg_addr_i == 4'h0;
  assign sw = cw && !run && reg_wdata_i[4];
  assign clr = reg_wr_i && clk_en_i && reg_addr_i == 4'h3 && reg_wdata_i[0];
  // Shadow of run state, latched fields, low-speed bit and mask
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run <= 1'b0;
      slow <= 1'b0;
      msk <= 1'b0;
      ck <= 3'h0;
      md <= 3'h0;
    end else if (clk_en_i && reg_wr_i) begin
      if (cw) begin
        run <= reg_wdata_i[4];
      end
      if (cw && !run) begin
        ck <= reg_wdata_i[3:1];
        md <= reg_wdata_i[7:5];
      end
      if (reg_addr_i == 4'h7) begin
        slow <= reg_wdata_i[1];
      end
      if (reg_addr_i == 4'h4) begin
        msk <= reg_wdata_i[0];
      end
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_idle;
    clk_en_i && !run |-> !count_tick_o;
  endproperty
  a_idle: assert property (p_idle) else $error("tick while stopped");
  property p_fc;
    en && !md[2] && ck == 3'h6 && !slow |-> count_tick_o == fc_tick_i;
  endproperty
  a_fc: assert property (p_fc) else $error("fc source wrong");
  property p_fs;
    en && !md[2] && ck == 3'h4 |-> count_tick_o == fs_tick_i;
  endproperty
  a_fs: assert property (p_fs) else $error("fs source wrong");
  property p_slow;
    en && !md[2] && slow && ck inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6} |-> !count_tick_o;
  endproperty
  a_slow: assert property (p_slow) else $error("fc source in slow mode");
  property p_casc;
    en && md[2] |-> count_tick_o == cascade_overflow_i;
  endproperty
  a_casc: assert property (p_casc) else $error("cascade source wrong");
  property p_ff;
    sw |=> timer_ff_o == $past(reg_wdata_i[0]);
  endproperty
  a_ff: assert property (p_ff) else $error("preset not loaded");
  property p_rd;
    clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_keep;
    clk_en_i && stage_match_interrupt_o && !clr |=> stage_match_interrupt_o;
  endproperty
  a_keep: assert property (p_keep) else $error("match flag lost");
  property p_clr;
    clr && !count_tick_o |=> !stage_match_interrupt_o;
  endproperty
  a_clr: assert property (p_clr) else $error("match flag not cleared");
  property p_irq;
    stage_match_interrupt_o && msk |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked flag without irq");
  c_start: cover property (sw);
  c_irq: cover property (stage_match_interrupt_o && irq_o);
  c_casc: cover property (en && md[2] && count_tick_o);
endmodule
bind utsc_top utsc_monitor i_utsc_monitor (.clock_i, .rst_b_i, .clk_en_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fc_tick_i, .fs_tick_i,
  .cascade_overflow_i, .timer_ff_o, .count_tick_o, .stage_match_interrupt_o, .irq_o);

// File: verilog/utsc_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UTSC_PARAMS_SVH
`define UTSC_PARAMS_SVH
`define UTSC_ADDR_CONTROL 4'h0
`define UTSC_ADDR_COMPARE 4'h1
`define UTSC_ADDR_DUTY 4'h2
`define UTSC_ADDR_STATUS 4'h3
`define UTSC_ADDR_MASK 4'h4
`define UTSC_ADDR_LOWER 4'h5
`define UTSC_ADDR_COUNT 4'h6
`define UTSC_ADDR_SYSCFG 4'h7
`define UTSC_CTL_FF_BIT 0
`define UTSC_CTL_CK_LSB 1
`define UTSC_CTL_RUN_BIT 4
`define UTSC_CTL_MODE_LSB 5
`define UTSC_CTL_RESET 8'h00
`define UTSC_CMP_RESET 8'hFF
`define UTSC_DUTY_RESET 8'h00
`define UTSC_LOWER_RESET 8'h00
`define UTSC_STAT_MATCH 0
`define UTSC_STAT_OVF 1
`define UTSC_SYS_DIVSEL_BIT 0
`define UTSC_SYS_SLOW_BIT 1
`define UTSC_DIV_FC11 11
`define UTSC_DIV_FC7 7
`define UTSC_DIV_FC5 5
`define UTSC_DIV_FC3 3
`define UTSC_DIV_FS3 3
`endif

// File: verilog/utsc_pkg.sv
// Types for the upper timer stage control
package utsc_pkg;
  typedef enum logic [2:0] {
    UTSC_MODE_TIMER8 = 3'b000,
    UTSC_MODE_DIVIDER8 = 3'b001,
    UTSC_MODE_PWM8 = 3'b010,
    UTSC_MODE_RESERVED = 3'b011,
    UTSC_MODE_TIMER16 = 3'b100,
    UTSC_MODE_WARMUP = 3'b101,
    UTSC_MODE_PWM16 = 3'b110,
    UTSC_MODE_PULSE16 = 3'b111
  } utsc_mode_e;
  typedef enum logic [2:0] {
    UTSC_CK_SLOWDIV = 3'b000,
    UTSC_CK_FC7 = 3'b001,
    UTSC_CK_FC5 = 3'b010,
    UTSC_CK_FC3 = 3'b011,
    UTSC_CK_FS = 3'b100,
    UTSC_CK_FC2 = 3'b101,
    UTSC_CK_FC = 3'b110,
    UTSC_CK_PIN = 3'b111
  } utsc_clk_e;
  typedef enum logic [0:0] {
    UTSC_ST_IDLE = 1'b0,
    UTSC_ST_RUN = 1'b1
  } utsc_state_e;
endpackage

// File: verilog/utsc_prescaler.sv
// Free-running prescaler producing one-cycle ticks at power-of-two rates
`timescale 1ns/10ps
module utsc_prescaler #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  // Base tick and divided ticks, bit n pulses every 2^n base ticks
  input wire logic tick_i,
  output logic [WIDTH-1:0] tick_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  always_comb begin
    next_count = count;
    if (enable_i && tick_i) begin
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  // Bit n fires as the low n count bits wrap to zero, once per 2^n ticks
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_tick
      if (g == 0) begin : g_base
        assign tick_o[g] = enable_i & tick_i;
      end else begin : g_div
        assign tick_o[g] = enable_i & tick_i & (count[g-1:0] == {g{1'b1}});
      end
    end
  endgenerate
endmodule

// File: verilog/utsc_sync.sv
// Two-flip-flop synchroniser with rising edge output
`timescale 1ns/10ps
module utsc_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  // Asynchronous level in, synchronous edge out
  input wire logic async_i,
  output logic rise_o
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;
  always_comb begin
    next_stage1 = enable_i ? async_i : stage1;
    next_stage2 = enable_i ? stage1 : stage2;
    next_stage3 = enable_i ? stage2 : stage3;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end
  assign rise_o = enable_i & stage2 & ~stage3;
endmodule

// File: verilog/utsc_top.sv
// Upper timer stage control: register file, source select, counter and flag
//
// Behaviour
// R1: One control, compare and duty register.
// R2: Three-bit clock select picks the source.
// R3: Slow modes allow only slow, fs, pin.
// R4: Run zero stops and clears; one starts.
// R5: Three 8-bit modes plus one reserved.
// R6: Four cascaded 16-bit modes.
// R7: Top mode bit: clock by cascade overflow.
// R8: Software sets lower mode to 011.
// R9: 16-bit: lower clock select, upper run.
// R10: Software keeps fields while running.
// R11: Fields take effect at start.
// R12: Preset bit sets output flip-flop start.
// R13: Software keeps compare while running.
// R14: Duty fixed while running except PWM.
// R15: Full fc in slow only warm-up; code blocks fc in slow mode, and warm-up counts cascade overflow.
// R16: Software keeps values within mode ranges.
// R17: Ranges: 1-255, 2-254, 256-65535.
// R18: 8-bit timer match interrupts and clears.
// R19: Mode codes follow list order.
`timescale 1ns/10ps
`include "utsc_params.svh"
module utsc_top #(
  parameter int CNT_WIDTH = 8,
  parameter int PRE_WIDTH = 12
) (
  // Clock, reset and freeze
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Clock sources: high and low frequency enables, external count pin
  input wire logic fc_tick_i,
  input wire logic fs_tick_i,
  input wire logic count_pin_i,
  // Cascade from the lower stage
  input wire logic cascade_overflow_i,
  // Stage outputs
  output logic timer_ff_o,
  output logic count_tick_o,
  output logic stage_match_interrupt_o,
  output logic irq_o
);
  logic [7:0] upper_timer_control;
  logic [7:0] upper_compare_value;
  logic [7:0] upper_duty_value;
  logic [7:0] lower_timer_control;
  logic [1:0] syscfg;
  logic [1:0] status;
  logic [1:0] mask;
  logic [CNT_WIDTH-1:0] count;
  logic timer_ff;
  logic [7:0] rdata;
  utsc_pkg::utsc_state_e state;
  logic [7:0] next_upper_timer_control;
  logic [7:0] next_upper_compare_value;
  logic [7:0] next_upper_duty_value;
  logic [7:0] next_lower_timer_control;
  logic [1:0] next_syscfg;
  logic [1:0] next_status;
  logic [1:0] next_mask;
  logic [CNT_WIDTH-1:0] next_count;
  logic next_timer_ff;
  logic [7:0] next_rdata;
  utsc_pkg::utsc_state_e next_state;
  logic [PRE_WIDTH-1:0] fc_div;
  logic [PRE_WIDTH-1:0] fs_div;
  logic pin_rise;
  logic run_bit;
  logic wr_ctl;
  logic [7:0] wdata_ctl;
  utsc_pkg::utsc_mode_e mode;
  utsc_pkg::utsc_clk_e clk_sel;
  utsc_pkg::utsc_clk_e lower_sel;
  logic divider_source_select;
  logic low_speed;
  logic sel_tick;
  logic tick;
  logic match;
  logic ovf;
  utsc_prescaler #(
    .WIDTH(PRE_WIDTH)
  ) u_fc_pre (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(clk_en_i),
    .tick_i(fc_tick_i),
    .tick_o(fc_div)
  );
  utsc_prescaler #(
    .WIDTH(PRE_WIDTH)
  ) u_fs_pre (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(clk_en_i),
    .tick_i(fs_tick_i),
    .tick_o(fs_div)
  );
  utsc_sync u_pin_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(clk_en_i),
    .async_i(count_pin_i),
    .rise_o(pin_rise)
  );
  assign mode = utsc_pkg::utsc_mode_e'(upper_timer_control[`UTSC_CTL_MODE_LSB +: 3]); // R19
  assign clk_sel = utsc_pkg::utsc_clk_e'(upper_timer_control[`UTSC_CTL_CK_LSB +: 3]);
  assign lower_sel = utsc_pkg::utsc_clk_e'(lower_timer_control[`UTSC_CTL_CK_LSB +: 3]);
  assign run_bit = upper_timer_control[`UTSC_CTL_RUN_BIT];
  assign divider_source_select = syscfg[`UTSC_SYS_DIVSEL_BIT];
  assign low_speed = syscfg[`UTSC_SYS_SLOW_BIT];
  assign wr_ctl = reg_wr_i && (reg_addr_i == `UTSC_ADDR_CONTROL);
  assign wdata_ctl = reg_wdata_i;
  // Source selection from the upper clock select
  always_comb begin
    sel_tick = 1'b0;
    case (clk_sel) // R2
      utsc_pkg::UTSC_CK_SLOWDIV: begin
        sel_tick = (divider_source_select || low_speed) ?
          fs_div[`UTSC_DIV_FS3] : fc_div[`UTSC_DIV_FC11];
      end
      utsc_pkg::UTSC_CK_FC7: begin
        sel_tick = !low_speed && fc_div[`UTSC_DIV_FC7]; // R3
      end
      utsc_pkg::UTSC_CK_FC5: begin
        sel_tick = !low_speed && fc_div[`UTSC_DIV_FC5]; // R3
      end
      utsc_pkg::UTSC_CK_FC3: begin
        sel_tick = !low_speed && fc_div[`UTSC_DIV_FC3]; // R3
      end
      utsc_pkg::UTSC_CK_FS: begin
        sel_tick = fs_div[0];
      end
      utsc_pkg::UTSC_CK_FC2: begin
        sel_tick = !low_speed && fc_div[1]; // R3
      end
      utsc_pkg::UTSC_CK_FC: begin
        sel_tick = !low_speed && fc_div[0]; // R3
      end
      utsc_pkg::UTSC_CK_PIN: begin
        sel_tick = pin_rise;
      end
      default: sel_tick = 1'b0;
    endcase
  end
  // Cascaded modes count on the lower stage overflow only
  assign tick = mode[2] ? cascade_overflow_i : sel_tick; // R7 R9
  assign match = (state == utsc_pkg::UTSC_ST_RUN) && tick &&
    (count == upper_compare_value[CNT_WIDTH-1:0]);
  assign ovf = (state == utsc_pkg::UTSC_ST_RUN) && tick && (&count);
  // Register writes; control fields other than run are accepted only when stopped or at start
  always_comb begin
    next_upper_timer_control = upper_timer_control;
    next_upper_compare_value = upper_compare_value;
    next_upper_duty_value = upper_duty_value;
    next_lower_timer_control = lower_timer_control;
    next_syscfg = syscfg;
    next_mask = mask;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `UTSC_ADDR_CONTROL: begin
          if (run_bit) begin
            next_upper_timer_control[`UTSC_CTL_RUN_BIT] = wdata_ctl[`UTSC_CTL_RUN_BIT]; // R4
          end else begin
            next_upper_timer_control = wdata_ctl; // R11 R1
          end
        end
        `UTSC_ADDR_COMPARE: begin
          next_upper_compare_value = reg_wdata_i; // R1
        end
        `UTSC_ADDR_DUTY: begin
          next_upper_duty_value = reg_wdata_i; // R1 R14
        end
        `UTSC_ADDR_LOWER: begin
          next_lower_timer_control = reg_wdata_i;
        end
        `UTSC_ADDR_SYSCFG: begin
          next_syscfg = reg_wdata_i[1:0];
        end
        `UTSC_ADDR_MASK: begin
          next_mask = reg_wdata_i[1:0];
        end
        default: next_syscfg = syscfg;
      endcase
    end
  end
  // Run state, counter and output flip-flop
  always_comb begin
    next_state = state;
    next_count = count;
    next_timer_ff = timer_ff;
    case (state)
      utsc_pkg::UTSC_ST_IDLE: begin
        next_count = '0;
        if (wr_ctl && wdata_ctl[`UTSC_CTL_RUN_BIT]) begin
          next_state = utsc_pkg::UTSC_ST_RUN; // R4
          next_timer_ff = wdata_ctl[`UTSC_CTL_FF_BIT]; // R12 R11
        end
      end
      utsc_pkg::UTSC_ST_RUN: begin
        if (wr_ctl && !wdata_ctl[`UTSC_CTL_RUN_BIT]) begin
          next_state = utsc_pkg::UTSC_ST_IDLE; // R4
          next_count = '0;
        end else if (match) begin
          next_count = '0; // R18
          if (mode == utsc_pkg::UTSC_MODE_DIVIDER8) begin
            next_timer_ff = ~timer_ff; // R5
          end
        end else if (tick) begin
          next_count = count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
        if (mode == utsc_pkg::UTSC_MODE_PWM8 || mode == utsc_pkg::UTSC_MODE_PWM16) begin
          if (tick && count == upper_duty_value[CNT_WIDTH-1:0]) begin
            next_timer_ff = ~upper_timer_control[`UTSC_CTL_FF_BIT]; // R5 R6
          end else if (ovf) begin
            next_timer_ff = upper_timer_control[`UTSC_CTL_FF_BIT]; // R6
          end
        end
      end
      default: next_state = utsc_pkg::UTSC_ST_IDLE;
    endcase
  end
  // Sticky status, set wins over write-one-to-clear
  always_comb begin
    next_status = status;
    if (reg_wr_i && reg_addr_i == `UTSC_ADDR_STATUS) begin
      next_status = status & ~reg_wdata_i[1:0];
    end
    if (match) begin
      next_status[`UTSC_STAT_MATCH] = 1'b1; // R18
    end
    if (ovf) begin
      next_status[`UTSC_STAT_OVF] = 1'b1;
    end
  end
  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `UTSC_ADDR_CONTROL: next_rdata = upper_timer_control;
        `UTSC_ADDR_COMPARE: next_rdata = upper_compare_value;
        `UTSC_ADDR_DUTY: next_rdata = upper_duty_value;
        `UTSC_ADDR_STATUS: next_rdata = {6'h00, status};
        `UTSC_ADDR_MASK: next_rdata = {6'h00, mask};
        `UTSC_ADDR_LOWER: next_rdata = lower_timer_control;
        `UTSC_ADDR_COUNT: next_rdata = 8'(count);
        `UTSC_ADDR_SYSCFG: next_rdata = {6'h00, syscfg};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  // Register file
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_timer_control <= `UTSC_CTL_RESET;
      upper_compare_value <= `UTSC_CMP_RESET;
      upper_duty_value <= `UTSC_DUTY_RESET;
      lower_timer_control <= `UTSC_LOWER_RESET;
      syscfg <= 2'h0;
      mask <= 2'h0;
    end else if (clk_en_i) begin
      upper_timer_control <= next_upper_timer_control;
      upper_compare_value <= next_upper_compare_value;
      upper_duty_value <= next_upper_duty_value;
      lower_timer_control <= next_lower_timer_control;
      syscfg <= next_syscfg;
      mask <= next_mask;
    end
  end
  // Run state, counter and output flip-flop
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
      timer_ff <= 1'b0;
      state <= utsc_pkg::UTSC_ST_IDLE;
    end else if (clk_en_i) begin
      count <= next_count;
      timer_ff <= next_timer_ff;
      state <= next_state;
    end
  end
  // Sticky status
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= 2'h0;
    end else if (clk_en_i) begin
      status <= next_status;
    end
  end
  // Read data register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= 8'h00;
    end else if (clk_en_i) begin
      rdata <= next_rdata;
    end
  end
  assign reg_rdata_o = rdata;
  assign timer_ff_o = timer_ff;
  assign count_tick_o = tick && (state == utsc_pkg::UTSC_ST_RUN);
  assign stage_match_interrupt_o = status[`UTSC_STAT_MATCH];
  assign irq_o = |(status & mask);
  logic unused_lower;
  assign unused_lower = &{1'b0, lower_sel};
endmodule
